// File: src/ccs_regs.v
// cell counters, receive subport position and pin-control / eeprom bit-bang registers
// assumes one clock; straps and eeprom data-in come from pins, cell pulses from logic
`timescale 1ns/1ps
`include "ccs_consts.vh"

module ccs_regs (
  input  wire        clock,          // 125 MHz system clock
  input  wire        resetn,         // asynchronous reset, active low
  input  wire        reg_wr,         // register write strobe
  input  wire        reg_rd,         // register read strobe
  input  wire [15:0] reg_addr,       // register address
  input  wire [7:0]  reg_wdata,      // write data
  output reg  [7:0]  reg_rdata,      // read data, valid with reg_rvalid
  output reg         reg_rvalid,     // read answer pulse
  input  wire        strap_input_first,  // first strap pin
  input  wire        strap_input_second, // second strap pin
  input  wire        rx_cell_done,   // one pulse per receive bus cell
  input  wire        tx_cell_done,   // one pulse per transmit bus cell
  input  wire        ldr_sclk,       // loader eeprom clock
  input  wire        ldr_cs_n,       // loader eeprom chip select, active low
  input  wire        ldr_dout,       // loader data toward eeprom
  output reg         ldr_din,        // eeprom data toward loader
  output reg         ee_sclk,        // eeprom clock pin
  output reg         ee_cs_n,        // eeprom chip select pin, active low
  output reg         ee_dout,        // eeprom data pin toward eeprom
  input  wire        ee_din,         // eeprom data pin from eeprom
  input  wire        hdr_valid,      // header word present for extraction
  input  wire [63:0] hdr_bytes,      // header byte 0 in [63:56]
  output reg  [6:0]  rx_subport,     // extracted subport, right justified
  output reg         rx_subport_valid // pulse with rx_subport
);

  // ****************************************************************
  // decode helper
  // ****************************************************************
  function sel;
    input [15:0] a;
    input [15:0] off;
    begin
      sel = (a == off);
    end
  endfunction

  // msb of the subport sits at flat index byte*8+(7-bit) counted from the header msb;
  // shifting by that index lets the field run into the next byte
  function [6:0] extract;
    input [63:0] hdr;
    input [2:0]  byte_loc;
    input [2:0]  bit_loc;
    input [2:0]  width;
    reg   [63:0] shifted;
    reg   [6:0]  top;
    reg   [5:0]  idx;
    begin
      idx     = {byte_loc, 3'h0} + {3'h0, 3'h7 - bit_loc};
      shifted = hdr << idx;
      top     = shifted[63:57];
      extract = top >> (3'h7 - width);
    end
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wire [2:0] pin_raw = {ee_din, strap_input_second, strap_input_first};
  wire [2:0] pin_s;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg meta_r;
      reg sync_r;
      always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= pin_raw[gi];
          sync_r <= meta_r;
        end
      end
      assign pin_s[gi] = sync_r;
    end
  endgenerate

  // ****************************************************************
  // registers
  // ****************************************************************
  reg        override_r;
  reg        ee_owner_r;
  reg        ee_sclk_r;
  reg        ee_cs_n_r;
  reg        ee_dout_r;
  reg [31:0] rx_cnt_r;
  reg [31:0] tx_cnt_r;
  reg [23:0] rx_snap_r;
  reg [23:0] tx_snap_r;
  reg [2:0]  sub_width_r;
  reg [2:0]  sub_byte_r;
  reg [2:0]  sub_bit_r;
  reg        strap_load_r;
  reg [1:0]  strap_wait_r;

  wire wr_pc    = reg_wr && sel(reg_addr, `CCS_ADDR_PIN_CTRL);
  wire wr_width = reg_wr && sel(reg_addr, `CCS_ADDR_SUB_WIDTH);
  wire wr_pos   = reg_wr && sel(reg_addr, `CCS_ADDR_SUB_POS);

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      override_r <= 1'b0;
      ee_owner_r <= 1'b0;
      ee_sclk_r  <= 1'b0;
      ee_cs_n_r  <= 1'b0;
      ee_dout_r  <= 1'b0;
    end else if (wr_pc) begin
      override_r <= reg_wdata[`CCS_PC_OVERRIDE];
      ee_owner_r <= reg_wdata[`CCS_PC_EE_OWNER];
      ee_sclk_r  <= reg_wdata[`CCS_PC_EE_SCLK];
      ee_cs_n_r  <= reg_wdata[`CCS_PC_EE_CS_N];
      ee_dout_r  <= reg_wdata[`CCS_PC_EE_DOUT];
    end
  end

  // ****************************************************************
  // cell counters
  // ****************************************************************
  // reading the msb byte freezes the lower three so a byte-wise read is coherent
  wire rd_rx_b3 = reg_rd && sel(reg_addr, `CCS_ADDR_RX_CNT_B3);
  wire rd_tx_b3 = reg_rd && sel(reg_addr, `CCS_ADDR_TX_CNT_B3);

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_cnt_r  <= `CCS_RST_COUNT;
      tx_cnt_r  <= `CCS_RST_COUNT;
      rx_snap_r <= 24'h000000;
      tx_snap_r <= 24'h000000;
    end else begin
      if (rx_cell_done)
        rx_cnt_r <= rx_cnt_r + 32'h0000_0001;
      if (tx_cell_done)
        tx_cnt_r <= tx_cnt_r + 32'h0000_0001;
      if (rd_rx_b3)
        rx_snap_r <= rx_cnt_r[23:0];
      if (rd_tx_b3)
        tx_snap_r <= tx_cnt_r[23:0];
    end
  end

  // ****************************************************************
  // subport configuration
  // ****************************************************************
  // the start byte is loaded from the synchronised straps on the fourth edge after
  // release, once both sync stages hold real pin levels
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      strap_wait_r <= 2'h0;
      strap_load_r <= 1'b0;
    end else begin
      if (strap_wait_r != 2'h3)
        strap_wait_r <= strap_wait_r + 2'h1;
      strap_load_r <= (strap_wait_r == 2'h2);
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sub_width_r <= `CCS_RST_SUB_WIDTH;
      sub_bit_r   <= `CCS_RST_SUB_BIT;
      sub_byte_r  <= `CCS_RST_SUB_BYTE;
    end else begin
      if (wr_width)
        sub_width_r <= reg_wdata[2:0];
      if (wr_pos)
        sub_bit_r <= reg_wdata[5:3];
      if (strap_load_r)
        sub_byte_r <= {1'b0, pin_s[1], pin_s[0]};
      else if (wr_pos && override_r)
        sub_byte_r <= reg_wdata[2:0];
    end
  end

  // ****************************************************************
  // eeprom pin routing
  // ****************************************************************
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ee_sclk <= 1'b0;
      ee_cs_n <= 1'b1;
      ee_dout <= 1'b0;
      ldr_din <= 1'b0;
    end else if (ee_owner_r) begin
      ee_sclk <= ee_sclk_r;
      ee_cs_n <= ee_cs_n_r;
      ee_dout <= ee_dout_r;
      ldr_din <= 1'b0;
    end else begin
      ee_sclk <= ldr_sclk;
      ee_cs_n <= ldr_cs_n;
      ee_dout <= ldr_dout;
      ldr_din <= pin_s[2];
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    case (reg_addr)
      `CCS_ADDR_PIN_CTRL: begin
        rd_mux[`CCS_PC_OVERRIDE]     = override_r;
        rd_mux[`CCS_PC_STRAP_FIRST]  = pin_s[0];
        rd_mux[`CCS_PC_STRAP_SECOND] = pin_s[1];
        rd_mux[`CCS_PC_EE_OWNER]     = ee_owner_r;
        rd_mux[`CCS_PC_EE_SCLK]      = ee_sclk_r;
        rd_mux[`CCS_PC_EE_CS_N]      = ee_cs_n_r;
        rd_mux[`CCS_PC_EE_DOUT]      = ee_dout_r;
        rd_mux[`CCS_PC_EE_DIN]       = ee_owner_r & pin_s[2];
      end
      `CCS_ADDR_RX_CNT_B3: rd_mux = rx_cnt_r[31:24];
      `CCS_ADDR_RX_CNT_B2: rd_mux = rx_snap_r[23:16];
      `CCS_ADDR_RX_CNT_B1: rd_mux = rx_snap_r[15:8];
      `CCS_ADDR_RX_CNT_B0: rd_mux = rx_snap_r[7:0];
      `CCS_ADDR_TX_CNT_B3: rd_mux = tx_cnt_r[31:24];
      `CCS_ADDR_TX_CNT_B2: rd_mux = tx_snap_r[23:16];
      `CCS_ADDR_TX_CNT_B1: rd_mux = tx_snap_r[15:8];
      `CCS_ADDR_TX_CNT_B0: rd_mux = tx_snap_r[7:0];
      `CCS_ADDR_SUB_WIDTH: rd_mux = {5'h00, sub_width_r};
      `CCS_ADDR_SUB_POS:   rd_mux = {2'h0, sub_bit_r, sub_byte_r};
      default:             rd_mux = 8'h00;
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_mux;
    end
  end

  // ****************************************************************
  // subport extraction
  // ****************************************************************
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_subport       <= 7'h00;
      rx_subport_valid <= 1'b0;
    end else begin
      rx_subport_valid <= hdr_valid;
      if (hdr_valid)
        rx_subport <= extract(hdr_bytes, sub_byte_r, sub_bit_r, sub_width_r);
    end
  end

endmodule // ccs_regs

// File: src/ccs_consts.vh
// constants for the cell count, subport and pin-control register group
// assumes byte-wide registers at 16-bit addresses, reached by in-band access
`ifndef CCS_CONSTS_VH
`define CCS_CONSTS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define CCS_ADDR_PIN_CTRL      16'h801A
`define CCS_ADDR_RX_CNT_B3     16'h801B
`define CCS_ADDR_RX_CNT_B2     16'h801C
`define CCS_ADDR_RX_CNT_B1     16'h801D
`define CCS_ADDR_RX_CNT_B0     16'h801E
`define CCS_ADDR_TX_CNT_B3     16'h801F
`define CCS_ADDR_TX_CNT_B2     16'h8020
`define CCS_ADDR_TX_CNT_B1     16'h8021
`define CCS_ADDR_TX_CNT_B0     16'h8022
`define CCS_ADDR_SUB_WIDTH     16'h8023
`define CCS_ADDR_SUB_POS       16'h8024

// ****************************************************************
// pin-control field positions
// ****************************************************************
`define CCS_PC_OVERRIDE        0
`define CCS_PC_STRAP_FIRST     1
`define CCS_PC_STRAP_SECOND    2
`define CCS_PC_EE_OWNER        3
`define CCS_PC_EE_SCLK         4
`define CCS_PC_EE_CS_N         5
`define CCS_PC_EE_DOUT         6
`define CCS_PC_EE_DIN          7

// ****************************************************************
// reset values
// ****************************************************************
`define CCS_RST_PIN_CTRL       8'h00
`define CCS_RST_COUNT          32'h0000_0000
`define CCS_RST_SUB_WIDTH      3'h5
`define CCS_RST_SUB_BIT        3'h5
`define CCS_RST_SUB_BYTE       3'h0

// ****************************************************************
// subport extraction sizes
// ****************************************************************
`define CCS_HDR_BITS           64
`define CCS_SUB_MAX            7

`endif

// File: dv/ccs_regs_monitor.sv
// assertions on the ports of the cell count / subport register group
// assumes the ccs_regs port list and a one-cycle read answer
`timescale 1ns/1ps
`include "ccs_consts.vh"
module ccs_regs_monitor (
  input wire        clock,            // system clock
  input wire        resetn,           // reset, active low
  input wire        reg_wr,           // write strobe
  input wire        reg_rd,           // read strobe
  input wire [15:0] reg_addr,         // address
  input wire [7:0]  reg_wdata,        // write data
  input wire [7:0]  reg_rdata,        // read data
  input wire        rx_cell_done,     // rx cell pulse
  input wire        tx_cell_done,     // tx cell pulse
  input wire        ldr_sclk,         // loader clock
  input wire        ldr_cs_n,         // loader select
  input wire        ldr_dout,         // loader data
  input wire        ldr_din,          // data to loader
  input wire        ee_sclk,          // eeprom clock pin
  input wire        ee_cs_n,          // eeprom select pin
  input wire        ee_dout,          // eeprom data pin
  input wire        hdr_valid,        // header strobe
  input wire        rx_subport_valid  // subport strobe
);
  // ****
  // shadow of owner and bit-bang bits, and of both counters
  // ****
  reg  [3:0]  pc_r;
  reg  [31:0] rx_r;
  reg  [31:0] tx_r;
  wire        sclk_w = pc_r[0] ? pc_r[1] : ldr_sclk;
  wire        csn_w  = pc_r[0] ? pc_r[2] : ldr_cs_n;
  wire        dout_w = pc_r[0] ? pc_r[3] : ldr_dout;
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pc_r <= 4'h0;
      rx_r <= 32'h0;
      tx_r <= 32'h0;
    end else begin
      if (reg_wr && reg_addr == `CCS_ADDR_PIN_CTRL)
        pc_r <= reg_wdata[6:3];
      rx_r <= rx_r + {31'h0, rx_cell_done};
      tx_r <= tx_r + {31'h0, tx_cell_done};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence rd_at(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence
  sclk_mux_a: assert property (ee_sclk == $past(sclk_w))
    else $error("eeprom clock pin wrong");
  csn_mux_a: assert property (ee_cs_n == $past(csn_w))
    else $error("eeprom select pin wrong");
  dout_mux_a: assert property (ee_dout == $past(dout_w))
    else $error("eeprom data pin wrong");
  ldr_quiet_a: assert property (pc_r[0] && $past(pc_r[0]) |-> !ldr_din)
    else $error("loader sees data while software owns");
  pc_read_a: assert property (rd_at(`CCS_ADDR_PIN_CTRL) |=> reg_rdata[6:3] == $past(pc_r))
    else $error("pin control readback wrong");
  rx_msb_a: assert property (rd_at(`CCS_ADDR_RX_CNT_B3) |=> reg_rdata == $past(rx_r[31:24]))
    else $error("rx count msb wrong");
  tx_msb_a: assert property (rd_at(`CCS_ADDR_TX_CNT_B3) |=> reg_rdata == $past(tx_r[31:24]))
    else $error("tx count msb wrong");
  width_pad_a: assert property (rd_at(`CCS_ADDR_SUB_WIDTH) |=> reg_rdata[7:3] == 5'h00)
    else $error("width spare bits not zero");
  pos_pad_a: assert property (rd_at(`CCS_ADDR_SUB_POS) |=> reg_rdata[7:6] == 2'h0)
    else $error("position spare bits not zero");
  sub_valid_a: assert property (hdr_valid |=> rx_subport_valid)
    else $error("subport strobe missing");
  sub_quiet_a: assert property (!hdr_valid |=> !rx_subport_valid)
    else $error("subport strobe without header");
endmodule // ccs_regs_monitor
bind ccs_regs ccs_regs_monitor u_mon (.clock, .resetn, .reg_wr, .reg_rd, .reg_addr,
  .reg_wdata, .reg_rdata, .rx_cell_done, .tx_cell_done, .ldr_sclk, .ldr_cs_n, .ldr_dout,
  .ldr_din, .ee_sclk, .ee_cs_n, .ee_dout, .hdr_valid, .rx_subport_valid);

// File: dv/ccs_regs_tb.sv
// self-checking bench for the cell count / subport register group
// assumes ccs_regs with a strobe register port and one-cycle read answer
`timescale 1ns/1ps
`include "ccs_consts.vh"
module ccs_regs_tb;
  reg         clock, resetn, reg_wr, reg_rd, strap_input_first, strap_input_second;
  reg         rx_cell_done, tx_cell_done, ldr_sclk, ldr_cs_n, ldr_dout, ee_din, hdr_valid;
  reg  [15:0] reg_addr;
  reg  [7:0]  reg_wdata, d;
  reg  [63:0] hdr_bytes;
  wire [7:0]  reg_rdata;
  wire [6:0]  rx_subport;
  wire        reg_rvalid, ldr_din, ee_sclk, ee_cs_n, ee_dout, rx_subport_valid;
  integer     num_errors, checks, i;
  ccs_regs dut (.clock, .resetn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .strap_input_first, .strap_input_second, .rx_cell_done, .tx_cell_done,
    .ldr_sclk, .ldr_cs_n, .ldr_dout, .ldr_din, .ee_sclk, .ee_cs_n, .ee_dout, .ee_din,
    .hdr_valid, .hdr_bytes, .rx_subport, .rx_subport_valid);
  // ****
  // tasks
  // ****
  task check(input [63:0] seen, input [63:0] exp, input [8*10-1:0] what);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %0h seen %0h", what, exp, seen);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task wr(input [15:0] a, input [7:0] v);
    begin
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clock);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [15:0] a, input [7:0] e);
    integer n;
    begin
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      for (n = 0; n < 4 && reg_rvalid !== 1'b1; n = n + 1) begin
        @(posedge clock);
        #1;
      end
      if (reg_rvalid !== 1'b1) begin
        num_errors = num_errors + 1;
        finish_test;
      end else begin
        check(reg_rdata, e, "reg_rdata");
      end
    end
  endtask
  // bit order: flat index counts from the msb of header byte 0
  function [6:0] sub_exp(input [2:0] by, input [2:0] bi, input [2:0] w);
    integer k, p;
    begin
      sub_exp = 7'h00;
      for (k = 0; k < w; k = k + 1) begin
        p = by * 8 + 7 - bi + k;
        sub_exp = {sub_exp[5:0], p < 64 ? hdr_bytes[63 - p] : 1'b0};
      end
    end
  endfunction
  task sub(input [2:0] by, input [2:0] bi, input [2:0] w);
    begin
      wr(`CCS_ADDR_SUB_POS, {2'h0, bi, by});
      wr(`CCS_ADDR_SUB_WIDTH, {5'h00, w});
      @(posedge clock);
      hdr_valid <= 1'b1;
      @(posedge clock);
      hdr_valid <= 1'b0;
      #1;
      check(rx_subport_valid, 1'b1, "sub_valid");
      check(rx_subport, sub_exp(by, bi, w), "rx_subport");
    end
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    {resetn, reg_wr, reg_rd, rx_cell_done, tx_cell_done, hdr_valid} = 6'h00;
    {ldr_sclk, ldr_dout, ee_din, strap_input_second} = 4'h0;
    {ldr_cs_n, strap_input_first} = 2'h3;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    hdr_bytes = 64'h0123_4567_89AB_CDEF;
    num_errors = 0;
    checks = 0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    repeat (6) @(posedge clock);
    rd(`CCS_ADDR_PIN_CTRL, 8'h02);
    for (i = 0; i < 8; i = i + 1) rd(`CCS_ADDR_RX_CNT_B3 + i, 8'h00);
    rd(`CCS_ADDR_SUB_WIDTH, 8'h05);
    rd(`CCS_ADDR_SUB_POS, 8'h29);
    rd(16'h8025, 8'h00);
    $display("reset values done");
    // strap byte stays locked until the override is set
    wr(`CCS_ADDR_SUB_POS, 8'hFA);
    rd(`CCS_ADDR_SUB_POS, 8'h39);
    wr(`CCS_ADDR_PIN_CTRL, 8'h01);
    wr(`CCS_ADDR_SUB_POS, 8'hC6);
    rd(`CCS_ADDR_SUB_POS, 8'h06);
    wr(`CCS_ADDR_SUB_WIDTH, 8'hFF);
    rd(`CCS_ADDR_SUB_WIDTH, 8'h07);
    @(posedge clock);
    strap_input_first <= 1'b0;
    strap_input_second <= 1'b1;
    repeat (4) @(posedge clock);
    rd(`CCS_ADDR_PIN_CTRL, 8'h05);
    $display("write protection done");
    for (i = 0; i < 5; i = i + 1) begin
      @(posedge clock);
      rx_cell_done <= (i < 3);
      tx_cell_done <= 1'b1;
    end
    @(posedge clock);
    rx_cell_done <= 1'b0;
    tx_cell_done <= 1'b0;
    for (i = 0; i < 3; i = i + 1) rd(`CCS_ADDR_RX_CNT_B3 + i, 8'h00);
    rd(`CCS_ADDR_RX_CNT_B0, 8'h03);
    for (i = 0; i < 3; i = i + 1) rd(`CCS_ADDR_TX_CNT_B3 + i, 8'h00);
    rd(`CCS_ADDR_TX_CNT_B0, 8'h05);
    $display("cell counters done");
    ee_din <= 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
      d = i ? 8'h29 : 8'h59;
      wr(`CCS_ADDR_PIN_CTRL, d);
      @(posedge clock);
      #1;
      check({ee_sclk, ee_cs_n, ee_dout}, {d[4], d[5], d[6]}, "ee_pins");
    end
    rd(`CCS_ADDR_PIN_CTRL, 8'hAD);
    check(ldr_din, 1'b0, "ldr_din");
    @(posedge clock);
    {ldr_sclk, ldr_cs_n, ldr_dout} <= 3'h5;
    wr(`CCS_ADDR_PIN_CTRL, 8'h01);
    repeat (2) @(posedge clock);
    #1;
    check({ee_sclk, ee_cs_n, ee_dout}, 3'h5, "ee_pins");
    check(ldr_din, 1'b1, "ldr_din");
    rd(`CCS_ADDR_PIN_CTRL, 8'h05);
    $display("eeprom routing done");
    sub(3'h0, 3'h5, 3'h5);
    sub(3'h1, 3'h2, 3'h5);
    sub(3'h7, 3'h0, 3'h7);
    sub(3'h3, 3'h7, 3'h0);
    $display("subport extraction done");
    finish_test;
  end
endmodule // ccs_regs_tb
